// ---- rtl/xps_ctrl.sv ----
// Serial configuration controller end: makes the link clock and drives the pins
`timescale 1ns/1ps
`default_nettype none
module xps_ctrl
	import xps_pkg::*;
#(
	parameter int FRAME = XPS_FRAME,
	parameter int WLEN  = XPS_WORD,
	parameter int HALF  = XPS_HALF_CYC
)(
	input  wire logic             clock_i,
	input  wire logic             reset_n_i,
	xps_if.ctrl                   link,
	input  wire logic             start_i,
	input  wire logic             mode_i,
	input  wire logic [FRAME-1:0] frame_i,
	input  wire logic [WLEN-1:0]  word_i,
	input  wire logic             cfg_req_i,
	input  wire logic             rst_pin_i,
	input  wire logic             bcast_pin_i,
	output var  logic             busy_o,
	output var  logic             done_o,
	output var  logic [FRAME-1:0] rx_o
);
	localparam int CW = $clog2(HALF) + 1;
	localparam int LW = $clog2(FRAME) + 1;
	localparam logic [CW-1:0] HALF_M1 = CW'(HALF - 1);

	if (HALF < XPS_SETUP_CYC || HALF < XPS_SYNC_STAGES + 1 || WLEN > FRAME)
	begin : g_chk
		$error("xps_ctrl: half period too short or word too long");
	end

	typedef enum logic [7:0] {
		C_IDLE  = 8'h01,
		C_LEAD  = 8'h02,
		C_HIGH  = 8'h04,
		C_LOW   = 8'h08,
		C_TAIL  = 8'h10,
		C_TAILH = 8'h20,
		C_CFG   = 8'h40,
		C_GAP   = 8'h80
	} xps_cstate_t;

	xps_cstate_t      state;
	logic [CW-1:0]    cnt;
	logic [LW-1:0]    left;
	logic [FRAME-1:0] sh;
	logic             sclk;
	logic             sel_n;
	logic             din;
	logic             cfg;
	logic             mode;
	logic             rst;
	logic             bcast;

	wire tick = cnt == '0;

	// Half-period divider; held reloaded while idle
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			cnt <= HALF_M1;
		else if (state == C_IDLE || tick)
			cnt <= HALF_M1;
		else
			cnt <= cnt - 1'b1;
	end

	// Pin sequencer: select low, N clock pulses with data set on each rise,
	// select high, then one more rising edge to close the frame
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state <= C_IDLE;
			sclk  <= 1'h0;
			sel_n <= 1'h1;
			din   <= 1'h0;
			cfg   <= 1'h0;
			mode  <= 1'h0;
			left  <= '0;
			sh    <= '0;
			rx_o  <= '0;
			done_o <= 1'h0;
		end
		else
		begin
			done_o <= 1'h0;
			unique case (state)
				C_IDLE:
					if (start_i)
					begin
						sh    <= mode_i ? FRAME'(word_i) : frame_i;
						left  <= mode_i ? LW'(WLEN) : LW'(FRAME);
						mode  <= mode_i;
						sel_n <= 1'h0;
						state <= C_LEAD;
					end
					else if (cfg_req_i)
					begin
						cfg   <= 1'h1;
						state <= C_CFG;
					end
				C_LEAD:
					if (tick)
					begin
						sclk  <= 1'h1;
						din   <= sh[0];
						rx_o  <= {link.dout, rx_o[FRAME-1:1]};
						state <= C_HIGH;
					end
				C_HIGH:
					if (tick)
					begin
						sclk  <= 1'h0;
						sh    <= sh >> 1;
						left  <= left - 1'b1;
						state <= C_LOW;
					end
				C_LOW:
					if (tick && left == '0)
					begin
						sel_n <= 1'h1;
						state <= C_TAIL;
					end
					else if (tick)
					begin
						sclk  <= 1'h1;
						din   <= sh[0];
						rx_o  <= {link.dout, rx_o[FRAME-1:1]};
						state <= C_HIGH;
					end
				C_TAIL:
					if (tick)
					begin
						sclk  <= 1'h1;
						state <= C_TAILH;
					end
				C_TAILH:
					if (tick)
					begin
						sclk   <= 1'h0;
						done_o <= 1'h1;
						state  <= C_IDLE;
					end
				C_CFG:
					if (tick)
					begin
						cfg   <= 1'h0;
						state <= C_GAP;
					end
				C_GAP:
					if (tick)
					begin
						done_o <= 1'h1;
						state  <= C_IDLE;
					end
			endcase
		end
	end

	// Special pins registered straight through; busy from the state and the start and configure requests
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst    <= 1'h0;
			bcast  <= 1'h0;
			busy_o <= 1'h0;
		end
		else
		begin
			rst    <= rst_pin_i;
			bcast  <= bcast_pin_i;
			busy_o <= (state != C_IDLE) || start_i || cfg_req_i;
		end
	end

	// Pins, all straight from flip-flops
	assign link.sclk          = sclk;
	assign link.sel_n         = sel_n;
	assign link.din           = din;
	assign link.cfg           = cfg;
	assign link.mode          = mode;
	assign link.rst           = rst;
	assign link.broadcast_pin = bcast;
endmodule : xps_ctrl
`default_nettype wire

// ---- rtl/xps_device.sv ----
// Crosspoint device end: serial staging bank and per-output active registers
`timescale 1ns/1ps
`default_nettype none
module xps_device
	import xps_pkg::*;
#(
	parameter int NOUT = XPS_NOUT,
	parameter int AW   = XPS_AW
)(
	input  wire logic                    clock_i,
	input  wire logic                    reset_n_i,
	xps_if.dev                           link,
	output var  logic [NOUT-1:0][AW-1:0] out_addr_o,
	output var  logic [NOUT-1:0]         out_off_o,
	output var  logic                    staged_new_o
);
	// Derived layout
	localparam int SLOT   = AW + 1;
	localparam int FRAME  = NOUT * SLOT;
	localparam int OSEL_W = $clog2(NOUT);
	localparam int WLEN   = OSEL_W + AW + 1;
	localparam int W_ADDR = OSEL_W;
	localparam int W_OFF  = OSEL_W + AW;
	localparam int CNT_W  = 8;

	if (NOUT < 2 || (1 << OSEL_W) != NOUT || AW < 1 || WLEN > FRAME)
	begin : g_chk
		$error("xps_device: geometry not supported");
	end

	// Link side, clocked by the serial clock
	logic [FRAME-1:0] shreg;
	logic [FRAME-1:0] hold;
	logic [CNT_W-1:0] shift_cnt;
	logic [CNT_W-1:0] close_cnt;
	logic             armed;
	logic             frame_tgl;

	wire sel_active = !link.sel_n;
	wire take_bit   = armed && sel_active;
	wire close_now  = armed && !sel_active;
	wire got_bits   = shift_cnt != close_cnt;

	// Arming: a rising edge with select low opens reception, with select high
	// closes it; nothing else moves while select stays high
	always_ff @(posedge link.sclk or negedge reset_n_i)
	begin
		if (!reset_n_i)
			armed <= 1'h0;
		else
			armed <= sel_active;
	end

	// Frame close on the rising edge after select rises; the hold copy stays
	// put until the next close, so the clock side can read it at leisure
	always_ff @(posedge link.sclk or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			hold      <= '0;
			frame_tgl <= 1'h0;
			close_cnt <= '0;
		end
		else if (close_now && got_bits)
		begin
			hold      <= shreg;
			frame_tgl <= ~frame_tgl;
			close_cnt <= shift_cnt;
		end
	end

	// Shift on falling edges; newest bit enters at the top, oldest leaves at
	// bit 0, so after a full frame the first bit sent sits at bit 0
	always_ff @(negedge link.sclk or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			shreg     <= '0;
			shift_cnt <= '0;
		end
		else if (take_bit)
		begin
			shreg     <= {link.din, shreg[FRAME-1:1]};
			shift_cnt <= shift_cnt + 1'b1;
		end
	end

	// Previous contents pass on to a chained device
	assign link.dout = shreg[0];

	// System clock side
	logic             s_tgl;
	logic             s_cfg;
	logic             s_mode;
	logic             s_rst;
	logic             s_bcast;
	logic             tgl_seen;
	logic             cfg_prev;
	logic             pending;
	logic [FRAME-1:0] staged;

	// Pins and the frame toggle arrive from foreign timing
	xps_sync #(
		.W (5)
	) u_sync (
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.async_i   ({frame_tgl, link.cfg, link.mode, link.rst, link.broadcast_pin}),
		.sync_o    ({s_tgl, s_cfg, s_mode, s_rst, s_bcast})
	);

	// Events on the clock side
	wire frame_arrived = s_tgl != tgl_seen;
	wire cfg_rise      = s_cfg && !cfg_prev;
	wire apply         = cfg_rise && pending && !s_rst;

	// Addressed word is the last WLEN bits shifted, top of the bank
	wire [WLEN-1:0]   word  = staged[FRAME-WLEN +: WLEN];
	wire [OSEL_W-1:0] w_out = word[0 +: OSEL_W];
	wire [AW-1:0]     w_adr = word[W_ADDR +: AW];
	wire              w_off = word[W_OFF];

	logic [NOUT-1:0][AW-1:0] next_addr;
	logic [NOUT-1:0]         next_off;

	// Per-output next value: reset beats broadcast beats configure
	for (genvar o = 0; o < NOUT; o++)
	begin : g_out
		wire [AW-1:0] f_adr = staged[o*SLOT +: AW];
		wire          f_off = staged[o*SLOT + AW];
		wire          hit   = s_mode ? (w_out == OSEL_W'(o)) : 1'h1;
		wire [AW-1:0] c_adr = s_mode ? w_adr : f_adr;
		wire          c_off = s_mode ? w_off : f_off;

		assign next_addr[o] = s_rst   ? XPS_RST_ADDR   :
		                      s_bcast ? XPS_BCAST_ADDR :
		                      (apply && hit) ? c_adr : out_addr_o[o];
		assign next_off[o]  = s_rst   ? XPS_OFF :
		                      s_bcast ? XPS_ON  :
		                      (apply && hit) ? c_off : out_off_o[o];
	end

	// Active registers, only ever loaded from the staged copy or the pins;
	// all outputs change in the same cycle so no output is half updated
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			out_addr_o <= {NOUT{XPS_RST_ADDR}};
			out_off_o  <= {NOUT{XPS_OFF}};
		end
		else
		begin
			out_addr_o <= next_addr;
			out_off_o  <= next_off;
		end
	end

	// Staged copy; a new frame sets pending even when a configure lands in
	// the same cycle, so it is taken by the following pulse
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			staged   <= '0;
			pending  <= 1'h0;
			tgl_seen <= 1'h0;
			cfg_prev <= 1'h0;
		end
		else
		begin
			tgl_seen <= s_tgl;
			cfg_prev <= s_cfg;
			if (s_rst)
			begin
				staged  <= '0;
				pending <= 1'h0;
			end
			else if (frame_arrived)
			begin
				staged  <= hold;
				pending <= 1'h1;
			end
			else if (apply)
				pending <= 1'h0;
		end
	end

	assign staged_new_o = pending;
endmodule : xps_device
`default_nettype wire

// ---- rtl/xps_if.sv ----
// Pin bundle between the serial controller and the crosspoint device
`timescale 1ns/1ps
`default_nettype none
interface xps_if;
	logic sclk;           // Serial clock, made by the controller
	logic sel_n;          // Select, active low
	logic din;            // Serial data into the device
	logic dout;           // Serial data out of the device
	logic cfg;            // Configure strobe, active high
	logic mode;           // 1 addressed word, 0 full frame
	logic rst;            // Device reset pin, active high
	logic broadcast_pin;  // Broadcast pin, active high

	modport dev (
		input  sclk,
		input  sel_n,
		input  din,
		output dout,
		input  cfg,
		input  mode,
		input  rst,
		input  broadcast_pin
	);
	modport ctrl (
		output sclk,
		output sel_n,
		output din,
		input  dout,
		output cfg,
		output mode,
		output rst,
		output broadcast_pin
	);
endinterface : xps_if
`default_nettype wire

// ---- rtl/xps_pkg.sv ----
// Shared constants for the crosspoint serial configuration port
package xps_pkg;
	// Matrix geometry
	localparam int XPS_NOUT         = 8;
	localparam int XPS_AW           = 4;
	localparam int XPS_FRAME        = 40;
	localparam int XPS_WORD         = 8;

	// Values loaded by the special control pins
	localparam logic [XPS_AW-1:0] XPS_RST_ADDR   = 4'h0;
	localparam logic [XPS_AW-1:0] XPS_BCAST_ADDR = 4'h0;
	localparam logic              XPS_OFF        = 1'h1;
	localparam logic              XPS_ON         = 1'h0;

	// Timing
	localparam int XPS_CLK_PERIOD_NS  = 10;
	localparam int XPS_LINK_PERIOD_NS = 160;
	localparam int XPS_SEL_SETUP_NS   = 5;
	localparam int XPS_HALF_CYC       = XPS_LINK_PERIOD_NS / (2 * XPS_CLK_PERIOD_NS);
	localparam int XPS_SETUP_CYC      =
		(XPS_SEL_SETUP_NS + XPS_CLK_PERIOD_NS - 1) / XPS_CLK_PERIOD_NS;
	localparam int XPS_SYNC_STAGES    = 3;
endpackage : xps_pkg

// ---- rtl/xps_sync.sv ----
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module xps_sync
	import xps_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         clock_i,
	input  wire logic         reset_n_i,
	input  wire logic [W-1:0] async_i,
	output var  logic [W-1:0] sync_o
);
	logic [W-1:0] stage1;
	logic [W-1:0] stage2;
	logic [W-1:0] stage3;

	if (W < 1)
	begin : g_chk
		$error("xps_sync: width must be positive");
	end

	// First stage feeds only the second; a change counts once stages agree
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_o <= '0;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				sync_o <= stage3;
		end
	end
endmodule : xps_sync
`default_nettype wire

// ---- test/tb_crosspoint_serial_config_port.sv ----
// Testbench joining controller and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
module tb_crosspoint_serial_config_port
	import xps_pkg::*;
;
	logic                             clock_i, reset_n_i, start_i, mode_i, cfg_req_i;
	logic                             rst_pin_i, bcast_pin_i, done_o, staged_new_o;
	logic [XPS_FRAME-1:0]             frame_i, rx_o, f_old, f_new;
	logic [XPS_WORD-1:0]              word_i;
	logic [XPS_NOUT-1:0][XPS_AW-1:0]  out_addr_o;
	logic [XPS_NOUT-1:0]              out_off_o, exp_off;
	logic [XPS_AW-1:0]                exp_addr [XPS_NOUT];
	int                               n_mismatch, samples_checked, cyc;

	xps_if link();
	xps_ctrl #(.HALF(4)) u_xps_ctrl (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link),
		.start_i(start_i), .mode_i(mode_i), .frame_i(frame_i), .word_i(word_i),
		.cfg_req_i(cfg_req_i), .rst_pin_i(rst_pin_i), .bcast_pin_i(bcast_pin_i),
		.busy_o(), .done_o(done_o), .rx_o(rx_o));
	xps_device u_xps_device (.clock_i(clock_i), .reset_n_i(reset_n_i), .link(link),
		.out_addr_o(out_addr_o), .out_off_o(out_off_o), .staged_new_o(staged_new_o));
	xps_assertions u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .sclk(link.sclk),
		.sel_n(link.sel_n), .din(link.din), .dout(link.dout), .cfg(link.cfg), .rst(link.rst),
		.broadcast_pin(link.broadcast_pin), .out_addr_o(out_addr_o), .out_off_o(out_off_o),
		.staged_new_o(staged_new_o));

	// 100 MHz system clock
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic final_report();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// Hang guard, sized well beyond the full sequence
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_mismatch++;
			final_report();
		end
	end

	// Pattern s: address per output and a sparse off mask
	function automatic logic [39:0] mk(input int s);
		logic [39:0] f;
		for (int o = 0; o < 8; o++)
			f[5*o +: 5] = {1'((o + s) % 4 == 0), 4'((o * s + 1) % 16)};
		return f;
	endfunction : mk

	task automatic set_exp(input logic [39:0] f);
		for (int o = 0; o < 8; o++)
			{exp_off[o], exp_addr[o]} = f[5*o +: 5];
	endtask : set_exp

	task automatic check_all();
		for (int o = 0; o < 8; o++)
			chk({out_off_o[o], out_addr_o[o]}, {exp_off[o], exp_addr[o]});
	endtask : check_all

	task automatic wait_done();
		int n;
		n = 0;
		while (done_o !== 1'b1 && n < 1000)
		begin
			@(negedge clock_i);
			n++;
		end
		// A controller that never finishes counts against the run
		if (done_o !== 1'b1)
			n_mismatch++;
		@(negedge clock_i);
	endtask : wait_done

	// Shift one transfer, then let the pending flag arrive
	task automatic xfer(input logic m, input logic [39:0] f, input logic [7:0] w);
		@(negedge clock_i);
		start_i = 1'b1;
		mode_i = m;
		frame_i = f;
		word_i = w;
		@(negedge clock_i);
		start_i = 1'b0;
		wait_done();
		repeat (8) @(negedge clock_i);
		chk(staged_new_o, 1'b1);
		check_all();
	endtask : xfer

	task automatic configure();
		@(negedge clock_i);
		cfg_req_i = 1'b1;
		@(negedge clock_i);
		cfg_req_i = 1'b0;
		wait_done();
		repeat (8) @(negedge clock_i);
	endtask : configure

	task automatic t_frame();
		f_old = mk(2);
		xfer(1'b0, f_old, 8'h00);
		configure();
		set_exp(f_old);
		check_all();
		chk(staged_new_o, 1'b0);
		configure();
		check_all();
	endtask : t_frame

	task automatic t_chain();
		f_new = mk(3);
		xfer(1'b0, f_new, 8'h00);
		chk(rx_o, f_old);
		configure();
		set_exp(f_new);
		check_all();
	endtask : t_chain

	task automatic t_addressed();
		logic [7:0] w [2];
		w[0] = {1'b0, 4'hA, 3'h5};
		w[1] = {1'b1, 4'hF, 3'h0};
		for (int i = 0; i < 2; i++)
		begin
			xfer(1'b1, 40'h00, w[i]);
			configure();
			{exp_off[w[i][2:0]], exp_addr[w[i][2:0]]} = w[i][7:3];
			check_all();
		end
	endtask : t_addressed

	task automatic t_pins();
		@(negedge clock_i);
		rst_pin_i = 1'b1;
		repeat (10) @(negedge clock_i);
		set_exp({8{5'h10}});
		check_all();
		rst_pin_i = 1'b0;
		repeat (10) @(negedge clock_i);
		check_all();
		bcast_pin_i = 1'b1;
		repeat (10) @(negedge clock_i);
		set_exp(40'h00);
		check_all();
		bcast_pin_i = 1'b0;
		repeat (10) @(negedge clock_i);
		check_all();
	endtask : t_pins

	// Main sequence
	initial
	begin
		{reset_n_i, start_i, mode_i, cfg_req_i, rst_pin_i, bcast_pin_i} = 6'h00;
		frame_i = 40'h00;
		word_i = 8'h00;
		n_mismatch = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (2) @(negedge clock_i);
		reset_n_i = 1'b1;
		repeat (2) @(negedge clock_i);
		set_exp({8{5'h10}});
		check_all();
		t_frame();
		t_chain();
		t_addressed();
		t_pins();
		final_report();
	end
endmodule : tb_crosspoint_serial_config_port
`default_nettype wire

// ---- test/xps_assertions.sv ----
// Concurrent checks on the crosspoint link pins and the active outputs
`timescale 1ns/1ps
`default_nettype none
module xps_assertions
	import xps_pkg::*;
(
	input wire logic                          clock_i,
	input wire logic                          reset_n_i,
	input wire logic                          sclk,
	input wire logic                          sel_n,
	input wire logic                          din,
	input wire logic                          dout,
	input wire logic                          cfg,
	input wire logic                          rst,
	input wire logic                          broadcast_pin,
	input wire logic [XPS_NOUT-1:0][XPS_AW-1:0] out_addr_o,
	input wire logic [XPS_NOUT-1:0]           out_off_o,
	input wire logic                          staged_new_o
);
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!reset_n_i);

	property p_setup; $fell(sel_n) |-> !sclk [*3]; endproperty
	property p_close; $rose(sel_n) |-> !sclk ##[1:8] $rose(sclk); endproperty
	property p_din; $fell(sclk) |-> $stable(din); endproperty
	property p_dout; $changed(dout) |-> $fell(sclk); endproperty
	property p_quiet; $fell(sclk) && sel_n |-> $stable(dout); endproperty
	property p_cfgw; $rose(cfg) |-> cfg [*4]; endproperty
	property p_apply; $rose(cfg) && staged_new_o |-> ##[1:7] !staged_new_o; endproperty
	property p_hold;
		(!cfg && !rst && !broadcast_pin) [*8] |-> $stable(out_addr_o) && $stable(out_off_o);
	endproperty
	property p_nonew;
		$rose(cfg) && !staged_new_o && !rst && !broadcast_pin
			|=> ($stable(out_addr_o) && $stable(out_off_o)) [*6];
	endproperty
	property p_rst; rst [*8] |-> out_off_o == '1 && out_addr_o == '0; endproperty
	property p_bc; (broadcast_pin && !rst) [*8] |-> out_off_o == '0 && out_addr_o == '0; endproperty

	a_setup: assert property (p_setup) else $error("clock rose too soon after select");
	a_close: assert property (p_close) else $error("no closing rise after select");
	a_din: assert property (p_din) else $error("data moved at sampling edge");
	a_dout: assert property (p_dout) else $error("data out moved off a falling edge");
	a_quiet: assert property (p_quiet) else $error("bank shifted with select high");
	a_cfgw: assert property (p_cfgw) else $error("configure pulse too short");
	a_apply: assert property (p_apply) else $error("pending flag not cleared");
	a_hold: assert property (p_hold) else $error("outputs moved without configure");
	a_nonew: assert property (p_nonew) else $error("empty configure changed outputs");
	a_rst: assert property (p_rst) else $error("reset pin not applied");
	a_bc: assert property (p_bc) else $error("broadcast pin not applied");

	// Main scenarios reached
	c_apply: cover property ($rose(cfg) && staged_new_o);
	c_rst: cover property (rst [*8]);
	c_bc: cover property (broadcast_pin [*8]);
endmodule : xps_assertions
`default_nettype wire
